// [volt_dependent_oc_function.sv]
// Purpose: Three-phase definite-time overcurrent with voltage dependent pickup
// Assumes: Fundamental magnitudes of currents and phase voltages are given
// Notes:   Settings over APB; events are sticky bits, write one to clear
//
// Notes on behaviour
// - Pickup threshold of each phase follows its fundamental voltage magnitude.
// - Operate timing works on each phase's fundamental current magnitude.
// - Each phase starts alone when its current exceeds its own threshold.
// - Each phase trips alone after staying started for the full delay.
// - Either block input suppresses all start and trip outputs.
// - General start is the OR of the three phase starts.
// - General trip is the OR of the three phase trips.
// - Mode bit picks restrained or controlled; restrained after reset.
// - Restrained, below low knee: threshold is start current times reduced percent.
// - Restrained, above high knee: threshold is the full start current.
// - Restrained, between knees: threshold rises linearly to full current.
// - Controlled: operation blocked when voltage is above the low knee.
// - Controlled: threshold is constant start current below low knee.
// - Separate start flags exist for phases one, two and three.
// - Per-phase trip flags are kept and readable as live status.
// - Changes of general start, phase starts or general trip raise events.
// - Operate delay settable 40 to 60000 ms in 1 ms steps, default 100.
// - Phases use line voltages one-two, two-three and three-one.
`default_nettype none
module volt_dependent_oc_function
    import vdoc_pkg::*;
#(
    parameter int MAG_W     = 16,
    parameter int MS_CYCLES_P = vdoc_pkg::MS_CYCLES
)(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [MAG_W-1:0] i_mag [3],
    input  wire logic [MAG_W-1:0] v_mag [3],
    input  wire logic             line_voltage_in,
    input  wire logic             general_block_in,
    input  wire logic             vt_supervision_block_in,
    output logic                  phase1_start_out,
    output logic                  phase2_start_out,
    output logic                  phase3_start_out,
    output logic                  phase1_trip_out,
    output logic                  phase2_trip_out,
    output logic                  phase3_trip_out,
    output logic                  general_start_out,
    output logic                  general_trip_out,
    output logic                  event_out
);
    import vdoc_pkg::*;

    if (MAG_W < 12 || MAG_W > 24 || MS_CYCLES_P < 1 || MS_CYCLES_P > 65535)
    begin : g_param_check
        $error("Unsupported parameter value");
    end

    // Settings
    logic        enable_reg,    enable_next;
    logic        mode_reg,      mode_next;
    logic [6:0]  low_knee_reg,  low_knee_next;
    logic [6:0]  high_knee_reg, high_knee_next;
    logic [6:0]  reduced_reg,   reduced_next;
    logic [11:0] start_cur_reg, start_cur_next;
    logic [15:0] delay_ms_reg,  delay_ms_next;
    logic [4:0]  event_reg,     event_next;
    logic [31:0] prdata_reg,    prdata_next;
    logic        pready_reg,    pready_next;
    logic        pslverr_reg,   pslverr_next;
    logic        event_any_reg, event_any_next;

    // Phase state
    phase_e      state_reg   [3];
    phase_e      state_next  [3];
    logic [15:0] presc_reg   [3];
    logic [15:0] presc_next  [3];
    logic [15:0] ms_reg      [3];
    logic [15:0] ms_next     [3];
    logic [7:0]  flags_reg,  flags_next;

    logic        active;
    logic        setup_ok;
    logic        access;
    logic [2:0]  start_w;
    logic [2:0]  trip_w;

    assign active   = enable_reg && !general_block_in && !vt_supervision_block_in;
    assign access   = psel && penable && !pready_reg;
    assign setup_ok = (paddr[1:0] == 2'b00) && (paddr <= EVENT_OFFS);

    // Register file and APB answer, one wait state
    always_comb
    begin
        enable_next    = enable_reg;
        mode_next      = mode_reg;
        low_knee_next  = low_knee_reg;
        high_knee_next = high_knee_reg;
        reduced_next   = reduced_reg;
        start_cur_next = start_cur_reg;
        delay_ms_next  = delay_ms_reg;
        event_next     = event_reg;
        prdata_next    = prdata_reg;
        pready_next    = access;
        pslverr_next   = access && !setup_ok;
        if (psel && penable && pready_reg && pwrite && setup_ok)
        begin
            case (paddr)
                CTRL_OFFS:
                begin
                    enable_next = pwdata[CTRL_EN_BIT];
                    mode_next   = pwdata[CTRL_MODE_BIT];
                end
                VOLT_OFFS:
                begin
                    if (pwdata[6:0] >= LOW_KNEE_MIN && pwdata[6:0] <= LOW_KNEE_MAX)
                        low_knee_next = pwdata[6:0];
                    if (pwdata[14:8] >= HIGH_KNEE_MIN && pwdata[14:8] <= HIGH_KNEE_MAX)
                        high_knee_next = pwdata[14:8];
                    if (pwdata[22:16] >= LOW_KNEE_MIN && pwdata[22:16] <= LOW_KNEE_MAX)
                        reduced_next = pwdata[22:16];
                end
                CURR_OFFS:
                    if (pwdata[11:0] >= START_CUR_MIN && pwdata[11:0] <= START_CUR_MAX)
                        start_cur_next = pwdata[11:0];
                DELAY_OFFS:
                    if (pwdata[15:0] >= DELAY_MS_MIN && pwdata[15:0] <= DELAY_MS_MAX)
                        delay_ms_next = pwdata[15:0];
                EVENT_OFFS:
                    event_next = event_reg & ~pwdata[4:0];
                default:
                    event_next = event_reg;
            endcase
        end
        event_next = event_next | (flags_next[4:0] ^ flags_reg[4:0]);
        event_any_next = |event_next;
        if (access)
        begin
            case (paddr)
                CTRL_OFFS:   prdata_next = {30'h0, mode_reg, enable_reg};
                VOLT_OFFS:   prdata_next = {9'h0, reduced_reg, 1'b0, high_knee_reg,
                                            1'b0, low_knee_reg};
                CURR_OFFS:   prdata_next = {20'h0, start_cur_reg};
                DELAY_OFFS:  prdata_next = {16'h0, delay_ms_reg};
                STATUS_OFFS: prdata_next = {24'h0, 2'b00, trip_w, start_w};
                EVENT_OFFS:  prdata_next = {27'h0, event_reg};
                default:     prdata_next = 32'h0;
            endcase
        end
    end

    // Per-phase decision
    for (genvar p = 0; p < 3; p++)
    begin : g_phase
        logic [MAG_W:0]   v_line;
        logic [MAG_W+7:0] v_pct;
        logic [MAG_W+7:0] thr;
        logic [MAG_W+7:0] i_scaled;
        logic             over;
        logic             under;
        logic             allowed;
        logic [6:0]       span;
        logic [13:0]      frac;

        // Line voltage of this phase pair, sum of the two phase values times 111/128 (about sqrt3/2) when built from phase values
        always_comb
        begin
            v_line = '0;
            v_pct  = '0;
            if (line_voltage_in)
                v_pct = {8'h0, v_mag[p]};
            else
            begin
                v_line = {1'b0, v_mag[p]} + {1'b0, v_mag[(p + 1) % 3]};
                v_pct  = {7'h0, v_line} * (MAG_W+8)'(111) >> 7;
            end
        end

        // Threshold in percent scaled by 128
        always_comb
        begin
            span    = high_knee_reg - low_knee_reg;
            frac    = '0;
            allowed = 1'b1;
            thr     = (MAG_W+8)'(start_cur_reg) << 7;
            if (mode_reg)
                allowed = (v_pct <= (MAG_W+8)'(low_knee_reg));
            else if (v_pct <= (MAG_W+8)'(low_knee_reg))
                thr = (MAG_W+8)'((MAG_W+8)'(start_cur_reg) * (MAG_W+8)'(reduced_reg)
                      * 128 / 100);
            else if (v_pct < (MAG_W+8)'(high_knee_reg) && span != 7'd0)
            begin
                frac = 14'((v_pct[13:0] - 14'(low_knee_reg)) * 128 / span);
                thr  = (MAG_W+8)'(((MAG_W+8)'(start_cur_reg) * (MAG_W+8)'(reduced_reg) * 128
                       + (MAG_W+8)'(start_cur_reg) * (MAG_W+8)'(7'd100 - reduced_reg)
                       * (MAG_W+8)'(frac)) / 100);
            end
            else
                thr = (MAG_W+8)'(start_cur_reg) << 7;
        end

        assign i_scaled = (MAG_W+8)'(i_mag[p]) << 7;
        assign over     = allowed && (i_scaled > thr);
        assign under    = !allowed || (i_scaled * 100 < thr * 95);

        always_comb
        begin
            state_next[p] = state_reg[p];
            presc_next[p] = presc_reg[p];
            ms_next[p]    = ms_reg[p];
            if (!active)
            begin
                state_next[p] = PH_IDLE;
                presc_next[p] = '0;
                ms_next[p]    = '0;
            end
            else
            begin
                case (state_reg[p])
                    PH_IDLE:
                    begin
                        presc_next[p] = '0;
                        ms_next[p]    = '0;
                        if (over)
                            state_next[p] = PH_STARTED;
                    end
                    PH_STARTED:
                    begin
                        if (under)
                        begin
                            state_next[p] = PH_IDLE;
                            presc_next[p] = '0;
                            ms_next[p]    = '0;
                        end
                        else if (presc_reg[p] == 16'(MS_CYCLES_P - 1))
                        begin
                            presc_next[p] = '0;
                            ms_next[p]    = ms_reg[p] + 16'd1;
                            if (ms_reg[p] + 16'd1 >= delay_ms_reg)
                                state_next[p] = PH_TRIPPED;
                        end
                        else
                            presc_next[p] = presc_reg[p] + 16'd1;
                    end
                    PH_TRIPPED:
                        if (under)
                            state_next[p] = PH_IDLE;
                    default:
                        state_next[p] = PH_IDLE;
                endcase
            end
        end

        assign start_w[p] = (state_next[p] != PH_IDLE);
        assign trip_w[p]  = (state_next[p] == PH_TRIPPED);

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                state_reg[p] <= PH_IDLE;
                presc_reg[p] <= '0;
                ms_reg[p]    <= '0;
            end
            else if (clk_en)
            begin
                state_reg[p] <= state_next[p];
                presc_reg[p] <= presc_next[p];
                ms_reg[p]    <= ms_next[p];
            end
        end
    end

    // Flags: phase starts, general start, general trip, phase trips
    always_comb
    begin
        flags_next = {trip_w, |trip_w, |start_w, start_w};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_reg    <= 1'b0;
            mode_reg      <= 1'b0;
            low_knee_reg  <= LOW_KNEE_RST;
            high_knee_reg <= HIGH_KNEE_RST;
            reduced_reg   <= REDUCED_RST;
            start_cur_reg <= START_CUR_RST;
            delay_ms_reg  <= DELAY_MS_RST;
            event_reg     <= '0;
            prdata_reg    <= '0;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            event_any_reg <= 1'b0;
            flags_reg     <= '0;
        end
        else if (clk_en)
        begin
            enable_reg    <= enable_next;
            mode_reg      <= mode_next;
            low_knee_reg  <= low_knee_next;
            high_knee_reg <= high_knee_next;
            reduced_reg   <= reduced_next;
            start_cur_reg <= start_cur_next;
            delay_ms_reg  <= delay_ms_next;
            event_reg     <= event_next;
            prdata_reg    <= prdata_next;
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
            event_any_reg <= event_any_next;
            flags_reg     <= flags_next;
        end
    end

    assign prdata            = prdata_reg;
    assign pready            = pready_reg;
    assign pslverr           = pslverr_reg;
    assign phase1_start_out  = flags_reg[0];
    assign phase2_start_out  = flags_reg[1];
    assign phase3_start_out  = flags_reg[2];
    assign general_start_out = flags_reg[3];
    assign general_trip_out  = flags_reg[4];
    assign phase1_trip_out   = flags_reg[5];
    assign phase2_trip_out   = flags_reg[6];
    assign phase3_trip_out   = flags_reg[7];
    assign event_out         = event_any_reg;
endmodule
`default_nettype wire

// [vdoc_pkg.sv]
// Purpose: Shared constants for the voltage dependent overcurrent block
// Assumes: Magnitudes arrive already filtered, in percent of rated value
// Notes:   Register offsets are byte addresses on a 32-bit APB bus
`default_nettype none
package vdoc_pkg;
    localparam int          CLK_HZ          = 40000000;
    localparam int          MS_CYCLES       = CLK_HZ / 1000;
    localparam logic [11:0] CTRL_OFFS       = 12'h000;
    localparam logic [11:0] VOLT_OFFS       = 12'h004;
    localparam logic [11:0] CURR_OFFS       = 12'h008;
    localparam logic [11:0] DELAY_OFFS      = 12'h00c;
    localparam logic [11:0] STATUS_OFFS     = 12'h010;
    localparam logic [11:0] EVENT_OFFS      = 12'h014;
    localparam int          CTRL_EN_BIT     = 0;
    localparam int          CTRL_MODE_BIT   = 1;
    localparam logic [6:0]  LOW_KNEE_RST    = 7'd30;
    localparam logic [6:0]  HIGH_KNEE_RST   = 7'd80;
    localparam logic [6:0]  REDUCED_RST     = 7'd30;
    localparam logic [11:0] START_CUR_RST   = 12'd200;
    localparam logic [15:0] DELAY_MS_RST    = 16'd100;
    localparam logic [6:0]  LOW_KNEE_MIN    = 7'd20;
    localparam logic [6:0]  LOW_KNEE_MAX    = 7'd60;
    localparam logic [6:0]  HIGH_KNEE_MIN   = 7'd60;
    localparam logic [6:0]  HIGH_KNEE_MAX   = 7'd110;
    localparam logic [11:0] START_CUR_MIN   = 12'd20;
    localparam logic [11:0] START_CUR_MAX   = 12'd3000;
    localparam logic [15:0] DELAY_MS_MIN    = 16'd40;
    localparam logic [15:0] DELAY_MS_MAX    = 16'd60000;
    typedef enum logic [1:0] {
        PH_IDLE    = 2'b00,
        PH_STARTED = 2'b01,
        PH_TRIPPED = 2'b10
    } phase_e;
endpackage
`default_nettype wire

// [vdoc_assertions.sv]
// Purpose: Port checks for the voltage dependent overcurrent block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Trip bound uses the shortest settable delay, 40 ms
`default_nettype none
module vdoc_assertions #(
    parameter int MAG_W       = 16,
    parameter int MS_CYCLES_P = 40000
)(
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pready,
    input wire logic [MAG_W-1:0] i_mag [3],
    input wire logic             general_block_in,
    input wire logic             vt_supervision_block_in,
    input wire logic             phase1_start_out,
    input wire logic             phase2_start_out,
    input wire logic             phase3_start_out,
    input wire logic             phase1_trip_out,
    input wire logic             phase2_trip_out,
    input wire logic             phase3_trip_out,
    input wire logic             general_start_out,
    input wire logic             general_trip_out,
    input wire logic             event_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MIN_RUN = 40 * MS_CYCLES_P - 2;
    wire logic   any_st = phase1_start_out | phase2_start_out | phase3_start_out;
    wire logic   any_tr = phase1_trip_out | phase2_trip_out | phase3_trip_out;
    wire logic   blk    = general_block_in | vt_supervision_block_in;
    logic [31:0] run_reg;
    logic [31:0] run_next;
    // Cycles that phase two has stayed started
    always_comb
    begin
        run_next = !phase2_start_out ? 32'h00000000 :
                   (&run_reg ? run_reg : run_reg + 32'h00000001);
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_reg <= 32'h00000000;
        else
            run_reg <= run_next;
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_gen_start_or: assert property (general_start_out == any_st)
        else $error("general start is not the OR of phase starts");
    a_gen_trip_or: assert property (general_trip_out == any_tr)
        else $error("general trip is not the OR of phase trips");
    a_block_clears: assert property (blk |=> !any_st && !any_tr && !general_trip_out)
        else $error("outputs active while blocked");
    a_start_cause: assert property ($rose(phase1_start_out) |->
        !$past(blk) && $past(i_mag[0]) > 4)
        else $error("phase one started without cause");
    a_trip_after_run: assert property ($rose(phase2_trip_out) |->
        $past(phase2_start_out) && run_reg >= MIN_RUN)
        else $error("phase two tripped too early");
    a_apb_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer on the second access edge");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_event_follow: assert property ($changed(general_trip_out) |-> ##[1:2] event_out)
        else $error("no event after general trip change");
    c_trip: cover property ($rose(general_trip_out));
    c_block: cover property (blk && any_st);
    c_phase3: cover property ($rose(phase3_start_out));
endmodule
bind volt_dependent_oc_function vdoc_assertions #(
    .MAG_W(MAG_W),
    .MS_CYCLES_P(MS_CYCLES_P)
) u_chk (.pclk, .presetn, .psel, .penable, .pready, .i_mag, .general_block_in,
    .vt_supervision_block_in, .phase1_start_out, .phase2_start_out, .phase3_start_out,
    .phase1_trip_out, .phase2_trip_out, .phase3_trip_out, .general_start_out,
    .general_trip_out, .event_out);
`default_nettype wire

// [vdoc_ct_vt_model.sv]
// Purpose: Transformer side source of filtered current and voltage magnitudes
// Assumes: Bench sets the wanted magnitudes
// Notes:   Magnitudes appear one cycle after they are set
`default_nettype none
module vdoc_ct_vt_model #(
    parameter int MAG_W = 16
)(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [MAG_W-1:0] i_set [3],
    input  wire logic [MAG_W-1:0] v_set [3],
    output logic      [MAG_W-1:0] i_mag [3],
    output logic      [MAG_W-1:0] v_mag [3]
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            i_mag <= '{default: '0};
            v_mag <= '{default: '0};
        end
        else
        begin
            i_mag <= i_set;
            v_mag <= v_set;
        end
    end
endmodule
`default_nettype wire

// [voltage_dependent_overcurrent_tb_top.sv]
// Purpose: Self-checking bench for the voltage dependent overcurrent block
// Assumes: Millisecond shortened to 4 clock cycles
// Notes:   Magnitudes reach the block through the transformer model
`default_nettype none
module voltage_dependent_overcurrent_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import vdoc_pkg::*;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, lv;
    logic        gblk, vblk, p1s, p2s, p3s, p1t, p2t, p3t, gs, gt, ev, rd_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic [15:0] i_set [3], v_set [3], i_mag [3], v_mag [3];
    int          err_count, checks;
    wire  [2:0]  st = {p3s, p2s, p1s};
    wire  [2:0]  tr = {p3t, p2t, p1t};
    vdoc_ct_vt_model #(.MAG_W(16)) u_src (.pclk, .presetn, .i_set, .v_set, .i_mag, .v_mag);
    volt_dependent_oc_function #(.MAG_W(16), .MS_CYCLES_P(4)) DUT (.pclk, .presetn, .clk_en,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .i_mag, .v_mag,
        .line_voltage_in(lv), .general_block_in(gblk), .vt_supervision_block_in(vblk),
        .phase1_start_out(p1s), .phase2_start_out(p2s), .phase3_start_out(p3s),
        .phase1_trip_out(p1t), .phase2_trip_out(p2t), .phase3_trip_out(p3t),
        .general_start_out(gs), .general_trip_out(gt), .event_out(ev));
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic drive(input logic [15:0] i0, i1, i2, v0, v1, v2);
        @(posedge pclk);
        i_set <= '{i0, i1, i2};
        v_set <= '{v0, v1, v2};
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic row(input logic [15:0] i0, i1, i2, v0, v1, v2, input logic [2:0] exp);
        drive(16'h0, 16'h0, 16'h0, v0, v1, v2);
        drive(i0, i1, i2, v0, v1, v2);
        chk(32'(st), 32'(exp));
        chk(32'(gs), 32'(|exp));
    endtask
    task automatic t_reset();
        apb(1'b0, CTRL_OFFS, 32'h0);
        chk(rd_data, 32'h00000000);
        apb(1'b0, VOLT_OFFS, 32'h0);
        chk(rd_data, 32'h001e501e);
        apb(1'b0, CURR_OFFS, 32'h0);
        chk(rd_data, 32'h000000c8);
        apb(1'b1, DELAY_OFFS, 32'h00000027);
        apb(1'b0, DELAY_OFFS, 32'h0);
        chk(rd_data, 32'h00000064);
        apb(1'b0, 12'h020, 32'h0);
        chk(32'(rd_err), 32'h1);
        row(16'h12c, 16'h12c, 16'h12c, 16'h0a, 16'h0a, 16'h0a, 3'h0);
    endtask
    task automatic t_restrained();
        apb(1'b1, CTRL_OFFS, 32'h1);
        row(16'hbe, 16'hbe, 16'hbe, 16'h64, 16'h64, 16'h64, 3'h0);
        row(16'hd2, 16'h0, 16'h0, 16'h64, 16'h64, 16'h64, 3'h1);
        row(16'h0, 16'hd2, 16'h0, 16'h64, 16'h64, 16'h64, 3'h2);
        row(16'h0, 16'h0, 16'hd2, 16'h64, 16'h64, 16'h64, 3'h4);
        row(16'h37, 16'h37, 16'h37, 16'h14, 16'h14, 16'h14, 3'h0);
        row(16'h41, 16'h41, 16'h41, 16'h14, 16'h14, 16'h14, 3'h7);
        row(16'h78, 16'h78, 16'h78, 16'h37, 16'h37, 16'h37, 3'h0);
        row(16'h8c, 16'h8c, 16'h8c, 16'h37, 16'h37, 16'h37, 3'h7);
    endtask
    task automatic t_trip();
        int n;
        apb(1'b1, DELAY_OFFS, 32'h00000028);
        drive(16'h0, 16'h0, 16'h0, 16'h64, 16'h64, 16'h64);
        apb(1'b1, EVENT_OFFS, 32'h0000001f);
        drive(16'h0, 16'h12c, 16'h0, 16'h64, 16'h64, 16'h64);
        for (n = 0; n < 300 && p2t !== 1'b1; n++)
            @(negedge pclk);
        chk(32'(n >= 150 && n <= 165), 32'h1);
        chk(32'({gt, tr}), 32'h0000000a);
        apb(1'b0, STATUS_OFFS, 32'h0);
        chk(rd_data, 32'h00000012);
        drive(16'h0, 16'hc3, 16'h0, 16'h64, 16'h64, 16'h64);
        chk(32'(st), 32'h2);
        drive(16'h0, 16'hb9, 16'h0, 16'h64, 16'h64, 16'h64);
        chk(32'({gt, st}), 32'h0);
        drive(16'h0, 16'h12c, 16'h0, 16'h64, 16'h64, 16'h64);
        chk(32'({gt, tr, st}), 32'h2);
        drive(16'h0, 16'h0, 16'h0, 16'h64, 16'h64, 16'h64);
        apb(1'b0, EVENT_OFFS, 32'h0);
        chk(rd_data, 32'h0000001a);
        apb(1'b1, EVENT_OFFS, 32'h0000001f);
        apb(1'b0, EVENT_OFFS, 32'h0);
        chk(32'({ev, rd_data[4:0]}), 32'h0);
    endtask
    task automatic t_block();
        for (int k = 0; k < 2; k++)
        begin
            drive(16'h12c, 16'h12c, 16'h12c, 16'h64, 16'h64, 16'h64);
            chk(32'(st), 32'h7);
            @(posedge pclk);
            gblk <= (k == 0);
            vblk <= (k == 1);
            repeat (2) @(negedge pclk);
            chk(32'({gs, gt, st}), 32'h0);
            @(posedge pclk);
            gblk <= 1'b0;
            vblk <= 1'b0;
        end
    endtask
    task automatic t_modes();
        apb(1'b1, CTRL_OFFS, 32'h3);
        row(16'h12c, 16'h12c, 16'h12c, 16'h32, 16'h32, 16'h32, 3'h0);
        row(16'hd2, 16'hd2, 16'hd2, 16'h1e, 16'h1e, 16'h1e, 3'h7);
        row(16'hbe, 16'hbe, 16'hbe, 16'h14, 16'h14, 16'h14, 3'h0);
        apb(1'b1, CTRL_OFFS, 32'h1);
        @(posedge pclk);
        lv <= 1'b0;
        row(16'h64, 16'h0, 16'h64, 16'h0a, 16'h0a, 16'h64, 3'h1);
    endtask
    task automatic complete_run();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, gblk, vblk} = 6'h00;
        {clk_en, lv, paddr, pwdata} = {2'h3, 12'h000, 32'h0};
        i_set = '{default: 16'h0};
        v_set = '{default: 16'h0};
        err_count = 0;
        checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_restrained();
        t_trip();
        t_block();
        t_modes();
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        complete_run();
    end
endmodule
`default_nettype wire
